// ### core/mdrv_regs_pkg.sv
package mdrv_regs_pkg;

  // Register word addresses
  localparam logic [7:0]  ADDR_IDENT        = 8'h08;
  localparam logic [7:0]  ADDR_UNUSED_FIRST = 8'h09;
  localparam logic [7:0]  ADDR_UNUSED_LAST  = 8'h2F;
  localparam logic [7:0]  ADDR_SPEED        = 8'h30;
  localparam logic [7:0]  ADDR_KEY          = 8'h31;
  localparam logic [7:0]  ADDR_NVM_STATUS   = 8'h32;

  // Field positions
  localparam int          SEL_BIT           = 15;
  localparam int          SPEED_MSB         = 8;
  localparam int          RSVD_MSB          = 14;
  localparam int          RSVD_LSB          = 9;
  localparam int          READY_BIT         = 0;

  // Reset values
  localparam logic [15:0] SPEED_RESET       = 16'h0000;
  localparam logic [15:0] KEY_RESET         = 16'h0000;

  // Customer space guarded by the unlock key
  localparam logic [15:0] NVM_UNLOCK_KEY    = 16'hC0DE;
  localparam logic [7:0]  NVM_CUST_FIRST    = 8'h90;
  localparam logic [7:0]  NVM_CUST_LAST     = 8'h96;

  // Serial framing
  localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_REG,
    ST_ACK_REG,
    ST_WDATA,
    ST_ACK_WDATA,
    ST_RDATA,
    ST_RACK
  } link_state_t;

endpackage : mdrv_regs_pkg

// ### core/mdrv_host_regs.sv
`timescale 1ns/1ps

module mdrv_host_regs
  import mdrv_regs_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR           = 7'h52,
  // Arbitrary identity values
  parameter logic [7:0] DIE_IDENTIFIER        = 8'hA5,
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h03
) (
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic [8:0] PIN_SPEED,
  input  wire logic       NVM_READY_FLAG,
  output logic            SPEED_SOURCE_SELECT,
  output logic [8:0]      SPEED_COMMAND,
  output logic            NVM_CUSTOMER_UNLOCKED
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       scl_m_q, scl_s_q, scl_p_q;
  logic       sda_m_q, sda_s_q, sda_p_q;
  logic       scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= SCL_IN;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= SDA_IN;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  assign scl_rise   = scl_s_q & ~scl_p_q;
  assign scl_fall   = ~scl_s_q & scl_p_q;
  assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ****************************************
  // Register file
  // ****************************************
  logic        sel_q, sel_d;
  logic [8:0]  speed_q, speed_d;
  logic [15:0] key_q, key_d;
  logic        unlocked_q, unlocked_d;
  logic [8:0]  cmd_q, cmd_d;
  logic        ready_q, ready_d;
  logic        wr_en;
  logic [7:0]  ptr_q, ptr_d;
  logic [7:0]  whi_q, whi_d;
  logic [7:0]  shift_q, shift_d;
  logic [15:0] word_cur, word_next;

  function automatic logic [15:0] read_word(input logic [7:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    case (addr)
      ADDR_IDENT:      w = {DIE_IDENTIFIER, SILICON_REVISION_CODE};
      ADDR_SPEED:      w = {sel_q, 6'h00, speed_q};
      ADDR_KEY:        w = key_q;
      ADDR_NVM_STATUS: w = {15'h0000, ready_q};
      default:         w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // A process, so that a register change alone also refreshes the read path
  always_comb begin
    word_cur  = read_word(ptr_q);
    word_next = read_word(ptr_q + 8'h01);
  end

  always_comb begin
    sel_d    = sel_q;
    speed_d  = speed_q;
    key_d    = key_q;
    ready_d  = NVM_READY_FLAG;
    if (wr_en) begin
      case (ptr_q)
        ADDR_SPEED: begin
          sel_d   = whi_q[SEL_BIT - 8];
          speed_d = {whi_q[SPEED_MSB - 8], shift_q};
        end
        ADDR_KEY: key_d = {whi_q, shift_q};
        default: ;
      endcase
    end
    unlocked_d = (key_d == NVM_UNLOCK_KEY);
    cmd_d = sel_d ? speed_d : PIN_SPEED;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sel_q      <= SPEED_RESET[SEL_BIT];
      speed_q    <= SPEED_RESET[SPEED_MSB:0];
      key_q      <= KEY_RESET;
      unlocked_q <= 1'b0;
      cmd_q      <= 9'h000;
      ready_q    <= 1'b0;
    end else begin
      sel_q      <= sel_d;
      speed_q    <= speed_d;
      key_q      <= key_d;
      unlocked_q <= unlocked_d;
      cmd_q      <= cmd_d;
      ready_q    <= ready_d;
    end
  end

  // ****************************************
  // Serial link engine
  // ****************************************
  link_state_t state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  tx_q, tx_d;
  logic        rw_q, rw_d;
  logic        hi_q, hi_d;
  logic        oe_q, oe_d;
  logic        sda_out_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    tx_d    = tx_q;
    rw_d    = rw_q;
    hi_d    = hi_q;
    oe_d    = oe_q;
    ptr_d   = ptr_q;
    whi_d   = whi_q;
    wr_en   = 1'b0;
    if (start_cond) begin
      // Repeated start keeps the pointer for a following read
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      oe_d    = 1'b0;
    end else if (stop_cond) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          shift_d = {shift_q[6:0], sda_s_q};
          cnt_d   = cnt_q + 4'h1;
        end
        ST_RDATA: begin
          tx_d  = {tx_q[6:0], 1'b0};
          cnt_d = cnt_q + 4'h1;
        end
        ST_RACK: begin
          if (sda_s_q) begin
            // Master NACK ends the read burst
            state_d = ST_IDLE;
          end else begin
            state_d = ST_RDATA;
            cnt_d   = 4'h0;
            if (!hi_q) begin
              tx_d = word_cur[7:0];
              hi_d = 1'b1;
            end else begin
              tx_d  = word_next[15:8];
              ptr_d = ptr_q + 8'h01;
              hi_d  = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            if (shift_q[7:1] == DEVICE_ADDR) begin
              state_d = ST_ACK_ADDR;
              rw_d    = shift_q[0];
              oe_d    = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            state_d = ST_RDATA;
            tx_d    = word_cur[15:8];
            hi_d    = 1'b0;
            oe_d    = ~word_cur[15];
          end else begin
            state_d = ST_REG;
            oe_d    = 1'b0;
          end
        end
        ST_REG: begin
          if (cnt_q == BITS_PER_BYTE) begin
            ptr_d   = shift_q;
            state_d = ST_ACK_REG;
            oe_d    = 1'b1;
          end
        end
        ST_ACK_REG, ST_ACK_WDATA: begin
          if (state_q == ST_ACK_REG) begin
            hi_d = 1'b0;
          end
          state_d = ST_WDATA;
          cnt_d   = 4'h0;
          oe_d    = 1'b0;
        end
        ST_WDATA: begin
          if (cnt_q == BITS_PER_BYTE) begin
            state_d = ST_ACK_WDATA;
            oe_d    = 1'b1;
            hi_d    = ~hi_q;
            if (!hi_q) begin
              whi_d = shift_q;
            end else begin
              // Word commits on its low byte
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          if (cnt_q == BITS_PER_BYTE) begin
            state_d = ST_RACK;
            oe_d    = 1'b0;
          end else begin
            oe_d = ~tx_q[7];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      rw_q      <= 1'b0;
      hi_q      <= 1'b0;
      oe_q      <= 1'b0;
      ptr_q     <= 8'h00;
      whi_q     <= 8'h00;
      sda_out_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      shift_q   <= shift_d;
      tx_q      <= tx_d;
      rw_q      <= rw_d;
      hi_q      <= hi_d;
      oe_q      <= oe_d;
      ptr_q     <= ptr_d;
      whi_q     <= whi_d;
      // Open drain: only ever pulls low
      sda_out_q <= 1'b0;
    end
  end

  assign SDA_OUT               = sda_out_q;
  assign SDA_OE                = oe_q;
  assign SPEED_SOURCE_SELECT   = sel_q;
  assign SPEED_COMMAND         = cmd_q;
  assign NVM_CUSTOMER_UNLOCKED = unlocked_q;

endmodule : mdrv_host_regs

// ### tb/mdrv_host_regs_checker.sv
`timescale 1ns/1ps
module mdrv_host_regs_checker (
  input wire logic       CLOCK,
  input wire logic       RESETN,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic [8:0] PIN_SPEED,
  input wire logic       NVM_READY_FLAG,
  input wire logic       SPEED_SOURCE_SELECT,
  input wire logic [8:0] SPEED_COMMAND,
  input wire logic       NVM_CUSTOMER_UNLOCKED
);
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // Writes commit near an ACK, so state may only move shortly after one
  always_comb begin
    quiet_d = SDA_OE ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) quiet_q <= 4'hF;
    else quiet_q <= quiet_d;
  end
  property p_out; SDA_OUT == 1'b0; endproperty
  a_out: assert property (p_out) else $error("data output high");
  // Sampled reset term skips the edge at which reset lifts
  property p_pin;
    RESETN && !SPEED_SOURCE_SELECT ##1 !SPEED_SOURCE_SELECT
      |-> SPEED_COMMAND == $past(PIN_SPEED);
  endproperty
  a_pin: assert property (p_pin) else $error("command not from pin");
  // A commit shows at the same edge as the ACK pull starts, so skip cycles with the pull on
  property p_host;
    SPEED_SOURCE_SELECT && !SDA_OE && quiet_q == 4'hF |-> $stable(SPEED_COMMAND);
  endproperty
  a_host: assert property (p_host) else $error("host command moved");
  property p_sel; $changed(SPEED_SOURCE_SELECT) |-> $rose(SDA_OE); endproperty
  a_sel: assert property (p_sel) else $error("select moved unasked");
  property p_key; $changed(NVM_CUSTOMER_UNLOCKED) |-> $rose(SDA_OE); endproperty
  a_key: assert property (p_key) else $error("unlock moved unasked");
  property p_oe; $changed(SDA_OE) |-> !SCL_IN; endproperty
  a_oe: assert property (p_oe) else $error("data moved with clock high");
  property p_start; $fell(SDA_IN) && SCL_IN |=> !SDA_OE [*8]; endproperty
  a_start: assert property (p_start) else $error("pull after start");
  property p_stop; $rose(SDA_IN) && SCL_IN |=> !SDA_OE [*4]; endproperty
  a_stop: assert property (p_stop) else $error("pull after stop");
  c_sel: cover property ($rose(SPEED_SOURCE_SELECT));
  c_key: cover property ($rose(NVM_CUSTOMER_UNLOCKED));
  c_ack: cover property ($rose(SDA_OE));
endmodule : mdrv_host_regs_checker
bind mdrv_host_regs mdrv_host_regs_checker checker_inst (.CLOCK(CLOCK), .RESETN(RESETN),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .PIN_SPEED(PIN_SPEED), .NVM_READY_FLAG(NVM_READY_FLAG),
  .SPEED_SOURCE_SELECT(SPEED_SOURCE_SELECT), .SPEED_COMMAND(SPEED_COMMAND),
  .NVM_CUSTOMER_UNLOCKED(NVM_CUSTOMER_UNLOCKED));

// ### tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
  import mdrv_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h52
) (
  input  wire logic CLOCK,
  input  wire logic SDA_OE,
  output logic      SCL_IN,
  output logic      SDA_IN
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // Pull-up: a released data line reads high
  assign SCL_IN = scl_q;
  assign SDA_IN = sda_q & ~SDA_OE;
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_q <= b;
    tick(7);
    scl_q <= 1'b1;
    tick(4);
    r = SDA_IN;
    tick(4);
    scl_q <= 1'b0;
  endtask : bit_io
  task automatic frame(input logic stop);
    tick(1);
    sda_q <= stop ? 1'b0 : 1'b1;
    tick(8);
    scl_q <= 1'b1;
    tick(8);
    sda_q <= stop ? 1'b1 : 1'b0;
    tick(8);
    if (!stop) scl_q <= 1'b0;
  endtask : frame
  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
  endtask : put
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : get
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    frame(1'b0);
    put({DEV_ADDR, 1'b0});
    put(a);
    put((a == ADDR_SPEED) ? d[15:8] & 8'h81 : d[15:8]);
    put(d[7:0]);
    frame(1'b1);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    frame(1'b0);
    put({DEV_ADDR, 1'b0});
    put(a);
    frame(1'b0);
    put({DEV_ADDR, 1'b1});
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    frame(1'b1);
  endtask : read_reg
  // Two words in one read, so the pointer steps across a word boundary
  task automatic read_pair(input logic [7:0] a, output logic [31:0] d);
    frame(1'b0);
    put({DEV_ADDR, 1'b0});
    put(a);
    frame(1'b0);
    put({DEV_ADDR, 1'b1});
    get(1'b0, d[31:24]);
    get(1'b0, d[23:16]);
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    frame(1'b1);
  endtask : read_pair
endmodule : i2c_host_model

// ### tb/motor_driver_host_control_regs_tb_top.sv
`timescale 1ns/1ps
module motor_driver_host_control_regs_tb_top
  import mdrv_regs_pkg::*;
;
  // Arbitrary identity values
  localparam logic [7:0] DIE = 8'h5A;
  localparam logic [7:0] REV = 8'h07;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [8:0]  pin = 9'h0C3;
  logic        ready = 1'b0;
  logic        scl, sda, sda_out, oe, sel, unl;
  logic [8:0]  cmd;
  logic [15:0] rd;
  logic [31:0] rd2;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #2.5 clock = ~clock;
  mdrv_host_regs #(.DIE_IDENTIFIER(DIE), .SILICON_REVISION_CODE(REV)) mdrv_host_regs_inst (
    .CLOCK(clock), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(oe), .PIN_SPEED(pin), .NVM_READY_FLAG(ready), .SPEED_SOURCE_SELECT(sel),
    .SPEED_COMMAND(cmd), .NVM_CUSTOMER_UNLOCKED(unl));
  i2c_host_model i2c_host_model_inst (.CLOCK(clock), .SDA_OE(oe), .SCL_IN(scl), .SDA_IN(sda));
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    i2c_host_model_inst.read_reg(a, rd);
    check(rd, e);
  endtask : rd_chk
  task automatic t_ident;
    i2c_host_model_inst.write_reg(ADDR_IDENT, 16'hFFFF);
    rd_chk(ADDR_IDENT, {DIE, REV});
    i2c_host_model_inst.write_reg(ADDR_UNUSED_FIRST, 16'h1234);
    rd_chk(ADDR_UNUSED_FIRST, 16'h0000);
    rd_chk(ADDR_UNUSED_LAST, 16'h0000);
    $display("ident test done");
  endtask : t_ident
  task automatic t_speed;
    rd_chk(ADDR_SPEED, SPEED_RESET);
    check({7'h00, cmd}, {7'h00, pin});
    i2c_host_model_inst.write_reg(ADDR_SPEED, 16'h81FF);
    pin <= 9'h0AA;
    rd_chk(ADDR_SPEED, 16'h81FF);
    check({15'h0000, sel}, 16'h0001);
    check({7'h00, cmd}, 16'h01FF);
    i2c_host_model_inst.write_reg(ADDR_SPEED, 16'h0055);
    check({7'h00, cmd}, 16'h00AA);
    rd_chk(ADDR_SPEED, 16'h0055);
    $display("speed test done");
  endtask : t_speed
  task automatic t_nvm;
    rd_chk(ADDR_KEY, KEY_RESET);
    i2c_host_model_inst.write_reg(ADDR_KEY, NVM_UNLOCK_KEY ^ 16'h0001);
    check({15'h0000, unl}, 16'h0000);
    i2c_host_model_inst.write_reg(ADDR_KEY, NVM_UNLOCK_KEY);
    rd_chk(ADDR_KEY, NVM_UNLOCK_KEY);
    i2c_host_model_inst.read_pair(ADDR_SPEED, rd2);
    check(rd2[31:16], 16'h0055);
    check(rd2[15:0], NVM_UNLOCK_KEY);
    check({15'h0000, unl}, 16'h0001);
    rd_chk(ADDR_NVM_STATUS, 16'h0000);
    ready <= 1'b1;
    for (int i = 0; i < 4 && rd[0] !== 1'b1; i++) i2c_host_model_inst.read_reg(ADDR_NVM_STATUS, rd);
    check(rd, 16'h0001);
    $display("nvm test done");
  endtask : t_nvm
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_ident();
    t_speed();
    t_nvm();
    end_sim();
  end
  // Full run needs about 12800 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count++;
      end_sim();
    end
  end
endmodule : motor_driver_host_control_regs_tb_top
